// ==== hw/tcmp_top.sv ====
// Timer and compare block with its classic Wishbone register slave
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tcmp_top #(
	parameter int ADR_W = 10
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic             ext_clk_i,
	input  wire logic             adc_enable_i,
	output logic                  cmp_pin_o,
	output logic                  cmp_pin_oe_o,
	output logic                  adc_start_o,
	output logic                  irq_o,
	output logic                  osc_en_o
);

	function automatic logic at(input logic [7:0] idx, input logic [7:0] off);
		at = (idx == off);
	endfunction

	tcmp_if tb ();

	// ==========================================================
	// Register state
	logic [7:0] pin_data_r;
	logic [7:0] ictl_r;
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] tctl_r;
	logic [7:0] cval_lo_r;
	logic [7:0] cval_hi_r;
	logic [7:0] cctl_r;
	logic [7:0] pin_dir_r;
	logic [7:0] irq_en_r;
	logic [7:0] rd_val;
	logic       ovf;

	// ==========================================================
	// Bus decode
	wire       req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       wr    = req & wb_we_i & wb_sel_i[0];
	wire [7:0] idx   = wb_adr_i[9:2];
	wire [7:0] wd    = wb_dat_i[7:0];

	wire w_pin_data = wr & at(idx, tcmp_pkg::OFF_PIN_DATA);
	wire w_ictl     = wr & (at(idx, tcmp_pkg::OFF_ICTL_A) |
		at(idx, tcmp_pkg::OFF_ICTL_B)); // R17
	wire w_flags    = wr & at(idx, tcmp_pkg::OFF_FLAGS);
	wire w_cnt_lo   = wr & at(idx, tcmp_pkg::OFF_CNT_LO);
	wire w_cnt_hi   = wr & at(idx, tcmp_pkg::OFF_CNT_HI);
	wire w_tctl     = wr & at(idx, tcmp_pkg::OFF_TCTL);
	wire w_cval_lo  = wr & at(idx, tcmp_pkg::OFF_CVAL_LO);
	wire w_cval_hi  = wr & at(idx, tcmp_pkg::OFF_CVAL_HI);
	wire w_cctl     = wr & at(idx, tcmp_pkg::OFF_CCTL);
	wire w_pin_dir  = wr & at(idx, tcmp_pkg::OFF_PIN_DIR);
	wire w_irq_en   = wr & at(idx, tcmp_pkg::OFF_IRQ_EN);

	// ==========================================================
	// Read mux, unmapped indexes read as zero
	always_comb begin
		rd_val = 8'h00;
		unique case (1'b1)
			at(idx, tcmp_pkg::OFF_PIN_DATA): rd_val = pin_data_r;
			at(idx, tcmp_pkg::OFF_ICTL_A):   rd_val = ictl_r;
			at(idx, tcmp_pkg::OFF_ICTL_B):   rd_val = ictl_r;
			at(idx, tcmp_pkg::OFF_FLAGS):    rd_val = flags_r;
			at(idx, tcmp_pkg::OFF_CNT_LO):   rd_val = tb.count[7:0];
			at(idx, tcmp_pkg::OFF_CNT_HI):   rd_val = tb.count[15:8];
			at(idx, tcmp_pkg::OFF_TCTL):     rd_val = tctl_r;
			at(idx, tcmp_pkg::OFF_CVAL_LO):  rd_val = cval_lo_r;
			at(idx, tcmp_pkg::OFF_CVAL_HI):  rd_val = cval_hi_r;
			at(idx, tcmp_pkg::OFF_CCTL):     rd_val = cctl_r;
			at(idx, tcmp_pkg::OFF_PIN_DIR):  rd_val = pin_dir_r;
			at(idx, tcmp_pkg::OFF_IRQ_EN):   rd_val = irq_en_r;
			default:                         rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= {24'h00_0000, rd_val};
		end
	end

	// ==========================================================
	// Flags: hardware sets beat a software clear in the same cycle
	assign flags_nxt = (w_flags ? (wd & tcmp_pkg::FLAGS_MASK) : flags_r) |
		({7'h00, ovf} << tcmp_pkg::FLAG_OVF) | // R2
		({7'h00, tb.match} << tcmp_pkg::FLAG_CMP); // R10

	wire any_irq = |(flags_r & irq_en_r & tcmp_pkg::FLAGS_MASK); // R3
	wire irq_nxt = ictl_r[tcmp_pkg::GLB_EN] &
		ictl_r[tcmp_pkg::PER_EN] & any_irq;

	// ==========================================================
	// Control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_data_r <= tcmp_pkg::RST_PIN_DATA;
			ictl_r     <= tcmp_pkg::RST_ICTL;
			flags_r    <= tcmp_pkg::RST_FLAGS;
			tctl_r     <= tcmp_pkg::RST_TCTL;
			cctl_r     <= tcmp_pkg::RST_CCTL;
			pin_dir_r  <= tcmp_pkg::RST_PIN_DIR;
			irq_en_r   <= tcmp_pkg::RST_IRQ_EN;
		end else begin
			if (w_pin_data)
				pin_data_r <= wd;
			if (w_ictl)
				ictl_r <= wd; // R17
			flags_r <= flags_nxt; // R14
			if (w_tctl)
				tctl_r <= wd & tcmp_pkg::CTL6_MASK; // R15
			if (w_cctl)
				cctl_r <= wd & tcmp_pkg::CTL6_MASK;
			if (w_pin_dir)
				pin_dir_r <= wd; // R18
			if (w_irq_en)
				irq_en_r <= wd & tcmp_pkg::FLAGS_MASK;
		end
	end

	// Compare value keeps its content over reset only in intent;
	// it is cleared here so that simulation never sees unknowns
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cval_lo_r <= 8'h00;
			cval_hi_r <= 8'h00;
		end else begin
			if (w_cval_lo)
				cval_lo_r <= wd;
			if (w_cval_hi)
				cval_hi_r <= wd;
		end
	end

	// ==========================================================
	// Outputs, each from a flip-flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o        <= 1'b0;
			adc_start_o  <= 1'b0;
			cmp_pin_oe_o <= 1'b0;
		end else begin
			irq_o        <= irq_nxt; // R3
			adc_start_o  <= tb.trig & adc_enable_i; // R4
			cmp_pin_oe_o <= ~pin_dir_r[tcmp_pkg::DIR_CMP]; // R11
		end
	end

	assign cmp_pin_o = tb.pin_lvl;
	assign osc_en_o  = tctl_r[tcmp_pkg::TCTL_OSC]; // R19

	// ==========================================================
	// Sub-blocks
	assign tb.cval    = {cval_hi_r, cval_lo_r};
	assign tb.mode    = cctl_r[3:0];
	assign tb.zero_wr = w_cctl & ((wd & tcmp_pkg::CTL6_MASK) == 8'h00); // R12

	count_unit u_count (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.run_i      (tctl_r[tcmp_pkg::TCTL_ON]),
		.ext_sel_i  (tctl_r[tcmp_pkg::TCTL_CS]),
		.prescale_i (tctl_r[tcmp_pkg::TCTL_PS +: 2]),
		.ext_clk_i  (ext_clk_i),
		.wr_lo_i    (w_cnt_lo),
		.wr_hi_i    (w_cnt_hi),
		.wdata_i    (wd),
		.tb         (tb.ctr),
		.ovf_o      (ovf)
	);

	compare_unit u_compare (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tb    (tb.cmp)
	);

	// ==========================================================
	// Checks
	property p_ovf_flag;
		@(posedge clk_i) disable iff (rst_i)
		ovf |=> flags_r[tcmp_pkg::FLAG_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // R2

	property p_ovf_sticky;
		@(posedge clk_i) disable iff (rst_i)
		(flags_r[tcmp_pkg::FLAG_OVF] && !w_flags) |=> flags_r[tcmp_pkg::FLAG_OVF];
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped"); // R2

	property p_irq_gate;
		@(posedge clk_i) disable iff (rst_i)
		(flags_r[tcmp_pkg::FLAG_OVF] && irq_en_r[tcmp_pkg::FLAG_OVF] &&
			ictl_r[tcmp_pkg::GLB_EN] && ictl_r[tcmp_pkg::PER_EN]) |=> irq_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("overflow irq not raised"); // R3

	property p_irq_quiet;
		@(posedge clk_i) disable iff (rst_i)
		(irq_en_r == 8'h00) |=> !irq_o;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without enable"); // R3

	property p_cmp_flag;
		@(posedge clk_i) disable iff (rst_i)
		tb.match |=> flags_r[tcmp_pkg::FLAG_CMP];
	endproperty
	a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set"); // R10

	property p_adc_start;
		@(posedge clk_i) disable iff (rst_i)
		(tb.trig && adc_enable_i) |=> adc_start_o ##1 !adc_start_o[*1];
	endproperty
	a_adc_start: assert property (p_adc_start) else $error("conversion start wrong"); // R4

	property p_oe;
		@(posedge clk_i) disable iff (rst_i)
		$fell(pin_dir_r[tcmp_pkg::DIR_CMP]) |=> cmp_pin_oe_o;
	endproperty
	a_oe: assert property (p_oe) else $error("pin not driven"); // R11

	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack timing"); // R14

endmodule

`default_nettype wire

// ==== hw/tcmp_pkg.sv ====
// Constants shared by the timer, compare unit and register slave
// How it works
// R1 - Counter pair counts up from 0000 to ffff, then wraps to 0000.
// R2 - Each wrap sets the overflow flag, which stays set until software clears it.
// R3 - Overflow flag reaches the interrupt output only while its enable bit is set.
// R4 - Special event match clears the counter and starts a conversion if converter enabled.
// R5 - A special event clear never sets the overflow flag.
// R6 - A counter write in the same cycle as a special event wins.
// R7 - Software uses internal or synchronised external counting with compare.
// R8 - In compare mode the compare value is compared against the counter continuously.
// R9 - A match drives the compare latch high, low or leaves it, per mode field.
// R10 - Every match sets the compare flag in the same cycle as the pin action.
// R11 - The compare pin is driven only while its direction bit is clear.
// R12 - Writing zero to compare control forces the compare latch low.
// R13 - Software interrupt mode leaves the pin alone and only sets the flag.
// R14 - Flag register holds converter, compare, second timer and overflow flags.
// R15 - Timer control holds prescale, oscillator, sync, source and run bits; resets zero.
// R16 - Counter low and high bytes are readable and writable.
// R17 - Interrupt control appears at two addresses, global and peripheral enables on top.
// R18 - Pin direction holds compare and clock pin directions, both reset to input.
// R19 - Oscillator enable bit turns on the low-power timer oscillator.
// R20 - Drive-high, drive-low and software-interrupt codes are chosen here.
`default_nettype none

package tcmp_pkg;

	// ==========================================================
	// Register indexes, byte address is four times the index
	localparam logic [7:0] OFF_PIN_DATA = 8'h07;
	localparam logic [7:0] OFF_ICTL_A   = 8'h0b;
	localparam logic [7:0] OFF_ICTL_B   = 8'h8b;
	localparam logic [7:0] OFF_FLAGS    = 8'h0c;
	localparam logic [7:0] OFF_CNT_LO   = 8'h0e;
	localparam logic [7:0] OFF_CNT_HI   = 8'h0f;
	localparam logic [7:0] OFF_TCTL     = 8'h10;
	localparam logic [7:0] OFF_CVAL_LO  = 8'h15;
	localparam logic [7:0] OFF_CVAL_HI  = 8'h16;
	localparam logic [7:0] OFF_CCTL     = 8'h17;
	localparam logic [7:0] OFF_PIN_DIR  = 8'h87;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h8c;

	// ==========================================================
	// Field positions
	localparam int FLAG_OVF  = 0;
	localparam int FLAG_T2   = 1;
	localparam int FLAG_CMP  = 2;
	localparam int FLAG_ADC  = 6;
	localparam int GLB_EN    = 7;
	localparam int PER_EN    = 6;
	localparam int TCTL_PS   = 4;
	localparam int TCTL_OSC  = 3;
	localparam int TCTL_SYNC = 2;
	localparam int TCTL_CS   = 1;
	localparam int TCTL_ON   = 0;
	localparam int DIR_CMP   = 2;
	localparam int DIR_EXT   = 0;
	localparam logic [7:0] FLAGS_MASK = 8'h47;
	localparam logic [7:0] CTL6_MASK  = 8'h3f;

	// ==========================================================
	// Reset values
	localparam logic [7:0]  RST_TCTL     = 8'h00;
	localparam logic [7:0]  RST_CCTL     = 8'h00;
	localparam logic [7:0]  RST_FLAGS    = 8'h00;
	localparam logic [7:0]  RST_IRQ_EN   = 8'h00;
	localparam logic [7:0]  RST_ICTL     = 8'h00;
	localparam logic [7:0]  RST_PIN_DIR  = 8'h05;
	localparam logic [7:0]  RST_PIN_DATA = 8'h00;
	localparam logic [15:0] RST_COUNT    = 16'h0000;
	localparam logic [15:0] COUNT_MAX    = 16'hffff;

	// ==========================================================
	// Compare mode codes
	localparam logic [1:0] MODE_CMP_HI  = 2'h2;
	localparam logic [3:0] MODE_HIGH    = 4'h8; // R20
	localparam logic [3:0] MODE_LOW     = 4'h9; // R20
	localparam logic [3:0] MODE_SWI     = 4'ha; // R20
	localparam logic [3:0] MODE_SPECIAL = 4'hb;

endpackage

`default_nettype wire

// ==== hw/tcmp_if.sv ====
// Signals between the register slave, counter and compare unit
`timescale 1ns/1ps
`default_nettype none

interface tcmp_if;
	logic [15:0] count;
	logic [15:0] cval;
	logic [3:0]  mode;
	logic        zero_wr;
	logic        match;
	logic        trig;
	logic        pin_lvl;

	modport ctr (output count, input trig);
	modport cmp (input count, cval, mode, zero_wr, output match, trig, pin_lvl);
endinterface

`default_nettype wire

// ==== hw/count_unit.sv ====
// Sixteen-bit up counter with prescaler and synchronised external clock
`timescale 1ns/1ps
`default_nettype none

module count_unit (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic       ext_sel_i,
	input  wire logic [1:0] prescale_i,
	input  wire logic       ext_clk_i,
	input  wire logic       wr_lo_i,
	input  wire logic       wr_hi_i,
	input  wire logic [7:0] wdata_i,
	tcmp_if.ctr             tb,
	output logic            ovf_o
);

	function automatic logic [2:0] ps_mask(input logic [1:0] ps);
		unique case (ps)
			2'h0: ps_mask = 3'h0;
			2'h1: ps_mask = 3'h1;
			2'h2: ps_mask = 3'h3;
			2'h3: ps_mask = 3'h7;
		endcase
	endfunction

	logic        s1_r;
	logic        s2_r;
	logic        s3_r;
	logic        lvl_r;
	logic [2:0]  pre_r;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;

	// ==========================================================
	// External clock: always synchronised, so compare stays safe
	wire agree    = (s2_r == s3_r);
	wire ext_rise = agree & s3_r & ~lvl_r; // R7
	wire src_tick = ext_sel_i ? ext_rise : 1'b1;
	wire [2:0] pm = ps_mask(prescale_i);
	wire pre_done = ((pre_r & pm) == pm);
	wire tick     = run_i & src_tick & pre_done;
	wire wr_any   = wr_lo_i | wr_hi_i;
	wire wrap     = tick & (cnt_r == tcmp_pkg::COUNT_MAX) & ~wr_any & ~tb.trig; // R5

	assign cnt_nxt = wr_lo_i ? {cnt_r[15:8], wdata_i} : // R6
		wr_hi_i ? {wdata_i, cnt_r[7:0]} : // R16
		tb.trig ? tcmp_pkg::RST_COUNT : // R4
		tick ? cnt_r + 16'h0001 : cnt_r; // R1
	assign tb.count = cnt_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r  <= 1'b0;
			s2_r  <= 1'b0;
			s3_r  <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			s1_r <= ext_clk_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree)
				lvl_r <= s3_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_r <= 3'h0;
			cnt_r <= tcmp_pkg::RST_COUNT;
			ovf_o <= 1'b0;
		end else begin
			if (run_i & src_tick)
				pre_r <= pre_done ? 3'h0 : pre_r + 3'h1;
			cnt_r <= cnt_nxt;
			ovf_o <= wrap;
		end
	end

	// ==========================================================
	// Checks
	property p_wrap;
		@(posedge clk_i) disable iff (rst_i)
		wrap |=> (cnt_r == 16'h0000) && ovf_o;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap did not reach zero"); // R1

	property p_trig_clear;
		@(posedge clk_i) disable iff (rst_i)
		(tb.trig && !wr_any) |=> (cnt_r == 16'h0000) && !ovf_o;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger clear wrong"); // R4

	property p_trig_no_ovf;
		@(posedge clk_i) disable iff (rst_i)
		tb.trig |=> !ovf_o;
	endproperty
	a_trig_no_ovf: assert property (p_trig_no_ovf) else $error("trigger set overflow"); // R5

	property p_write_wins;
		@(posedge clk_i) disable iff (rst_i)
		(tb.trig && wr_lo_i) |=> cnt_r[7:0] == $past(wdata_i);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("write lost to trigger"); // R6

endmodule

`default_nettype wire

// ==== hw/compare_unit.sv ====
// Equality compare with output latch and special event trigger
`timescale 1ns/1ps
`default_nettype none

module compare_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	tcmp_if.cmp      tb
);

	logic eq_r;
	logic lvl_r;
	logic lvl_nxt;

	// ==========================================================
	// Match fires on entry into equality, so a prescaled counter
	// sitting on the value for many cycles counts as one event
	wire in_cmp = (tb.mode[3:2] == tcmp_pkg::MODE_CMP_HI);
	wire eq     = (tb.count == tb.cval); // R8
	wire hit    = in_cmp & eq & ~eq_r;

	assign tb.match   = hit; // R10
	assign tb.trig    = hit & (tb.mode == tcmp_pkg::MODE_SPECIAL); // R4
	assign tb.pin_lvl = lvl_r;

	assign lvl_nxt = tb.zero_wr ? 1'b0 : // R12
		(hit & (tb.mode == tcmp_pkg::MODE_HIGH)) ? 1'b1 : // R9
		(hit & (tb.mode == tcmp_pkg::MODE_LOW)) ? 1'b0 : lvl_r; // R13

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eq_r  <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			eq_r  <= eq;
			lvl_r <= lvl_nxt;
		end
	end

	// ==========================================================
	// Checks
	property p_drive_high;
		@(posedge clk_i) disable iff (rst_i)
		(hit && tb.mode == tcmp_pkg::MODE_HIGH && !tb.zero_wr) |=> lvl_r;
	endproperty
	a_drive_high: assert property (p_drive_high) else $error("latch not driven high"); // R9

	property p_zero_low;
		@(posedge clk_i) disable iff (rst_i)
		tb.zero_wr |=> !lvl_r;
	endproperty
	a_zero_low: assert property (p_zero_low) else $error("latch not forced low"); // R12

	property p_swi_keep;
		@(posedge clk_i) disable iff (rst_i)
		(tb.mode == tcmp_pkg::MODE_SWI && !tb.zero_wr) |=> lvl_r == $past(lvl_r);
	endproperty
	a_swi_keep: assert property (p_swi_keep) else $error("pin moved in interrupt mode"); // R13

	property p_eq_match;
		@(posedge clk_i) disable iff (rst_i)
		(in_cmp && tb.count == tb.cval && !$past(tb.count == tb.cval)) |-> tb.match;
	endproperty
	a_eq_match: assert property (p_eq_match) else $error("equality missed"); // R8

endmodule

`default_nettype wire

// ==== test/pin_adc_model.sv ====
// Model of the compare pin pad and the converter start input
`timescale 1ns/1ps
`default_nettype none

module pin_adc_model (
	input  wire logic clk_i,
	input  wire logic pin_i,
	input  wire logic oe_i,
	input  wire logic adc_start_i,
	input  wire logic en_req_i,
	output logic      adc_en_o,
	output logic      pad_o,
	output int        starts_o
);
	logic last_r = 1'b0;

	assign adc_en_o = en_req_i;
	// The pad has no pull, so an undriven pad shows the inverse of the last level
	assign pad_o = oe_i ? pin_i : ~last_r;
	initial starts_o = 0;
	always @(posedge clk_i) begin
		if (oe_i === 1'b1)
			last_r <= pin_i;
		if (adc_start_i === 1'b1)
			starts_o <= starts_o + 1;
	end
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the timer and compare block
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [9:0]  wb_adr_i = 10'h000;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic        adc_req = 1'b0;
	logic        ext_clk = 1'b0;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, cmp_pin_o, cmp_pin_oe_o, adc_start_o, irq_o, osc_en_o, adc_en, pad;
	int          starts, fails = 0, comparisons = 0, cycles = 0, n, i, s0;
	logic [31:0] seed = 32'h4ddb;
	logic [31:0] rdat;
	logic [7:0]  cv;
	logic        pin_exp = 1'b0;
	logic [3:0]  modes [4];

	tcmp_top #(.ADR_W(10)) tcmp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk),
		.adc_enable_i(adc_en), .cmp_pin_o(cmp_pin_o), .cmp_pin_oe_o(cmp_pin_oe_o),
		.adc_start_o(adc_start_o), .irq_o(irq_o), .osc_en_o(osc_en_o));
	pin_adc_model pin_adc_model_inst (.clk_i(clk_i), .pin_i(cmp_pin_o), .oe_i(cmp_pin_oe_o),
		.adc_start_i(adc_start_o), .en_req_i(adc_req), .adc_en_o(adc_en), .pad_o(pad),
		.starts_o(starts));

	always #4 clk_i = ~clk_i;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task results;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			results;
		end
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled, then release
	task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'hf;
		wb_dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			chk("ack", 1, 0);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task wr(input logic [7:0] idx, input logic [7:0] d);
		wb(1'b1, idx, d);
	endtask

	task rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
		wb(1'b0, idx, 8'h00);
		chk(nm, {24'h0, e}, rdat);
	endtask

	task settle;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	task clear_count;
		wr(tcmp_pkg::OFF_TCTL, 8'h00);
		wr(tcmp_pkg::OFF_CNT_LO, 8'h00);
		wr(tcmp_pkg::OFF_CNT_HI, 8'h00);
		wr(tcmp_pkg::OFF_FLAGS, 8'h00);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		modes = '{tcmp_pkg::MODE_HIGH, tcmp_pkg::MODE_SWI, tcmp_pkg::MODE_LOW, tcmp_pkg::MODE_HIGH};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(tcmp_pkg::OFF_TCTL, tcmp_pkg::RST_TCTL, "tctl");
		rd(tcmp_pkg::OFF_CCTL, tcmp_pkg::RST_CCTL, "cctl");
		rd(tcmp_pkg::OFF_FLAGS, tcmp_pkg::RST_FLAGS, "flags");
		rd(tcmp_pkg::OFF_IRQ_EN, tcmp_pkg::RST_IRQ_EN, "irq_en");
		rd(tcmp_pkg::OFF_PIN_DIR, 8'h05, "pin_dir");
		rd(8'h3f, 8'h00, "unmapped");
		chk("oe", 0, cmp_pin_oe_o);
		wr(tcmp_pkg::OFF_TCTL, 8'hf8);
		rd(tcmp_pkg::OFF_TCTL, 8'h38, "tctl");
		chk("osc_en", 1, osc_en_o);
		wr(tcmp_pkg::OFF_ICTL_A, 8'hc0);
		rd(tcmp_pkg::OFF_ICTL_B, 8'hc0, "irq_ctl");
		seed = lfsr(seed);
		wr(tcmp_pkg::OFF_PIN_DATA, seed[23:16]);
		rd(tcmp_pkg::OFF_PIN_DATA, seed[23:16], "pin_data");
		wr(tcmp_pkg::OFF_CNT_LO, seed[7:0]);
		wr(tcmp_pkg::OFF_CNT_HI, seed[15:8]);
		rd(tcmp_pkg::OFF_CNT_LO, seed[7:0], "cnt_lo");
		rd(tcmp_pkg::OFF_CNT_HI, seed[15:8], "cnt_hi");
		wr(tcmp_pkg::OFF_FLAGS, 8'hff);
		rd(tcmp_pkg::OFF_FLAGS, 8'h47, "flags");
		// Counter wrap with overflow flag and its interrupt
		clear_count;
		wr(tcmp_pkg::OFF_CNT_LO, 8'hf0);
		wr(tcmp_pkg::OFF_CNT_HI, 8'hff);
		wr(tcmp_pkg::OFF_TCTL, 8'h01);
		repeat (40) @(posedge clk_i);
		wr(tcmp_pkg::OFF_TCTL, 8'h00);
		rd(tcmp_pkg::OFF_FLAGS, 8'h01, "flags");
		rd(tcmp_pkg::OFF_CNT_HI, 8'h00, "cnt_hi");
		wr(tcmp_pkg::OFF_IRQ_EN, 8'h01);
		settle;
		chk("irq", 1, irq_o);
		wr(tcmp_pkg::OFF_IRQ_EN, 8'h00);
		settle;
		chk("irq", 0, irq_o);
		rd(tcmp_pkg::OFF_FLAGS, 8'h01, "flags");
		// Compare pin actions: drive high, software interrupt, drive low, then drive high again
		wr(tcmp_pkg::OFF_PIN_DIR, 8'h00);
		settle;
		chk("oe", 1, cmp_pin_oe_o);
		for (i = 0; i < 4; i++) begin
			clear_count;
			seed = lfsr(seed);
			cv = 8'h20 + {4'h0, seed[3:0]};
			wr(tcmp_pkg::OFF_CVAL_LO, cv);
			wr(tcmp_pkg::OFF_CVAL_HI, 8'h00);
			wr(tcmp_pkg::OFF_CCTL, {4'h0, modes[i]});
			wr(tcmp_pkg::OFF_TCTL, 8'h01);
			repeat (60) @(posedge clk_i);
			wr(tcmp_pkg::OFF_TCTL, 8'h00);
			if (modes[i] == tcmp_pkg::MODE_HIGH)
				pin_exp = 1'b1;
			else if (modes[i] == tcmp_pkg::MODE_LOW)
				pin_exp = 1'b0;
			rd(tcmp_pkg::OFF_FLAGS, 8'h04, "flags");
			chk("pad", pin_exp, pad);
		end
		wr(tcmp_pkg::OFF_CCTL, 8'h00);
		settle;
		chk("pad", 0, pad);
		// Special event: periodic clear and converter start
		clear_count;
		wr(tcmp_pkg::OFF_CVAL_LO, 8'h10);
		wr(tcmp_pkg::OFF_CVAL_HI, 8'h00);
		adc_req <= 1'b1;
		wr(tcmp_pkg::OFF_CCTL, {4'h0, tcmp_pkg::MODE_SPECIAL});
		wr(tcmp_pkg::OFF_TCTL, 8'h01);
		repeat (100) @(posedge clk_i);
		wr(tcmp_pkg::OFF_TCTL, 8'h00);
		rd(tcmp_pkg::OFF_FLAGS, 8'h04, "flags");
		rd(tcmp_pkg::OFF_CNT_HI, 8'h00, "cnt_hi");
		wb(1'b0, tcmp_pkg::OFF_CNT_LO, 8'h00);
		chk("cnt_le_period", 1, rdat[7:0] <= 8'h10);
		chk("starts_min", 1, starts >= 5);
		adc_req <= 1'b0;
		s0 = starts;
		wr(tcmp_pkg::OFF_TCTL, 8'h01);
		repeat (100) @(posedge clk_i);
		wr(tcmp_pkg::OFF_TCTL, 8'h00);
		chk("starts_off", s0, starts);
		// Counter write lands on the edge of the match at 20h; ack rises on the same edge as the take
		clear_count;
		wr(tcmp_pkg::OFF_CVAL_LO, 8'h20);
		wr(tcmp_pkg::OFF_TCTL, 8'h01);
		repeat (30) @(posedge clk_i);
		wr(tcmp_pkg::OFF_CNT_LO, 8'h55);
		wr(tcmp_pkg::OFF_TCTL, 8'h00);
		rd(tcmp_pkg::OFF_CNT_LO, 8'h58, "write_wins");
		// Synchronised external clock source, one count per rising edge
		clear_count;
		seed = lfsr(seed);
		s0 = 3 + seed[2:0];
		wr(tcmp_pkg::OFF_TCTL, 8'h07);
		for (i = 0; i < s0; i++) begin
			ext_clk <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext_clk <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
		wr(tcmp_pkg::OFF_TCTL, 8'h00);
		rd(tcmp_pkg::OFF_CNT_LO, s0[7:0], "ext_count");
		results;
	end
endmodule

`default_nettype wire
